/* verilog/cmp_ctrl_pkg.sv */
// Package for the comparator control block: register indices, field
// positions, reset values and timing counts.
// Assumes a 20 MHz bus clock and a 32-bit AHB-Lite register port.
`default_nettype none
package cmp_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_ROUTING = 4'h1;
  localparam logic [3:0] IDX_IRQ_EN = 4'h2;
  localparam logic [3:0] IDX_STATUS = 4'h3;
  localparam logic [3:0] IDX_RSVD_LO = 4'h4;
  localparam logic [3:0] IDX_RSVD_HI = 4'h7;
  localparam logic [3:0] IDX_WAKE_MASK = 4'h8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_ENABLE = 7;
  localparam int CTL_PIN_EN = 6;
  localparam int CTL_POLARITY = 5;
  localparam int CTL_FILTER = 4;
  localparam int CTL_HYST_LO = 2;
  localparam int CTL_MODE_LO = 0;
  localparam int RT_POS_LO = 4;
  localparam int RT_NEG_LO = 0;
  localparam int IE_BIT = 0;
  localparam int ST_RESULT = 7;
  localparam int ST_FLAG = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] ROUTING_RST = 8'h00;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic MASK_RST = 1'b1;

  // ----------------------------------------------------------------
  // Edge modes and timing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_t;

  localparam int INIT_DELAY_CYCLES = 127;
  localparam logic [6:0] INIT_CNT_LOAD = 7'(INIT_DELAY_CYCLES - 1);

endpackage

`default_nettype wire

/* verilog/comparator_control.sv */
// Digital control and status logic around an analog comparator core.
// Assumes an AHB-Lite master on hclk, a free-running analog result and
// system stop and wait levels synchronous to hclk.
// Operation
// - The comparator is operational only while enabled and not in stop.
// - Wait mode alone never forces shutdown.
// - Each entry to normal mode runs a 127 bus clock initialization delay.
// - During that delay the result path to status, flag and timer is frozen.
// - Clearing the enable or entering stop puts the comparator in shutdown.
// - On entering shutdown the last comparator state is retained.
// - In shutdown with non-inverted polarity the output pin drives low.
// - Four sources, two pins and two internal, feed either comparator input.
// - An interrupt can follow a rising, falling or either edge.
// - The result can drive an output pin with selectable polarity.
// - A comparator-derived signal can trigger timer input capture.
// - The edge flag sets two clocks after the pin change and clears on write one.
// - Edge mode 00 disables, 01 rising, 10 falling, 11 both edges.
// - Input select writes take effect only while the enable is clear.
// - The interrupt asserts only while irq enable, edge flag and mask are set.
`timescale 1ns/1ps
`default_nettype none

module comparator_control
  import cmp_ctrl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // System modes
  input wire logic stop_mode,
  input wire logic wait_mode,
  // Analog core
  input wire logic cmp_raw,
  output logic core_enable,
  output logic [1:0] positive_input_select,
  output logic [1:0] negative_input_select,
  output logic [1:0] hysteresis_select,
  output logic filter_speed_select,
  // Pins and links
  output logic result_output_pin,
  output logic result_output_oe,
  output logic timer_capture,
  output logic irq
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_INIT = 2'b01,
    ST_RUN = 2'b11
  } run_state_t;

  run_state_t state_r;
  logic [7:0] control_r;
  logic [3:0] routing_r;
  logic irq_en_r;
  logic edge_flag_r;
  logic flag_mask_r;
  logic [6:0] init_cnt_r;
  logic [2:0] sync_r;
  logic synced_result_r;
  logic result_prev_r;
  logic pin_r;
  logic pin_d1_r;
  logic pin_d2_r;
  logic ap_valid_r;
  logic ap_write_r;
  logic [3:0] ap_idx_r;
  logic ap_hit_r;
  logic normal_req;
  logic settled;
  logic edge_hit;
  logic wr_en;
  logic wr_control;
  logic wr_routing;
  logic wr_irq_en;
  logic wr_mask;
  logic wr_status;
  logic [7:0] wdata;
  edge_mode_t edge_mode;

  // Byte address hit check, only aligned words in range
  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a[1:0] == 2'b00) && (a[31:6] == 26'h0);
  endfunction

  // Write strobe for one register of the map
  function automatic logic reg_write(
    input logic en,
    input logic [3:0] at,
    input logic [3:0] idx
  );
    reg_write = en && (at == idx);
  endfunction

  // Mode request; wait mode is not decoded, the core runs on through it
  assign edge_mode = edge_mode_t'(control_r[CTL_MODE_LO +: 2]);
  assign normal_req = control_r[CTL_ENABLE] && !stop_mode;
  assign settled = (state_r == ST_RUN);

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_idx_r <= 4'h0;
      ap_hit_r <= 1'b0;
    end
    else if (hready)
    begin
      ap_valid_r <= hsel && htrans[1];
      ap_write_r <= hwrite;
      ap_idx_r <= haddr[5:2];
      ap_hit_r <= addr_hit(haddr);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = ap_valid_r && ap_write_r && ap_hit_r;
  assign wdata = hwdata[7:0];

  // Per-register write strobes
  assign wr_control = reg_write(wr_en, ap_idx_r, IDX_CONTROL);
  assign wr_routing = reg_write(wr_en, ap_idx_r, IDX_ROUTING);
  assign wr_irq_en = reg_write(wr_en, ap_idx_r, IDX_IRQ_EN);
  assign wr_mask = reg_write(wr_en, ap_idx_r, IDX_WAKE_MASK);
  assign wr_status = reg_write(wr_en, ap_idx_r, IDX_STATUS);

  // Read mux, zero for reserved and unmapped
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (ap_valid_r && !ap_write_r && ap_hit_r)
    begin
      unique case (ap_idx_r)
        IDX_CONTROL: hrdata[7:0] = control_r;
        IDX_ROUTING: hrdata[7:0] = {2'b00, routing_r[3:2], 2'b00, routing_r[1:0]};
        IDX_IRQ_EN: hrdata[IE_BIT] = irq_en_r;
        IDX_STATUS:
        begin
          hrdata[ST_RESULT] = synced_result_r;
          hrdata[ST_FLAG] = edge_flag_r;
        end
        IDX_WAKE_MASK: hrdata[0] = flag_mask_r;
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------

  // Control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      control_r <= CONTROL_RST;
    else if (wr_control)
      control_r <= wdata;
  end

  // Routing, writable only while disabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      routing_r <= ROUTING_RST[3:0];
    else if (wr_routing && !control_r[CTL_ENABLE])
      routing_r <= {wdata[RT_POS_LO +: 2], wdata[RT_NEG_LO +: 2]};
  end

  // Interrupt enable and mask
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_en_r <= IRQ_EN_RST;
      flag_mask_r <= MASK_RST;
    end
    else
    begin
      if (wr_irq_en)
        irq_en_r <= wdata[IE_BIT];
      if (wr_mask)
        flag_mask_r <= wdata[0];
    end
  end

  // ------------------------------------------------------------
  // Mode sequencing
  // ------------------------------------------------------------

  // Shutdown, initialization delay and normal run
  // Init counts down from the load value to zero, so it spans the full delay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_OFF;
      init_cnt_r <= 7'h00;
    end
    else
    begin
      unique case (state_r)
        ST_OFF:
          if (normal_req)
          begin
            state_r <= ST_INIT;
            init_cnt_r <= INIT_CNT_LOAD;
          end
        ST_INIT:
          if (!normal_req)
            state_r <= ST_OFF;
          else if (init_cnt_r == 7'h00)
            state_r <= ST_RUN;
          else
            init_cnt_r <= init_cnt_r - 7'h01;
        ST_RUN:
          if (!normal_req)
            state_r <= ST_OFF;
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Result path
  // ------------------------------------------------------------

  // Three-stage synchronizer on the analog result
  // Only the second stage reads the first; the third guards the compare
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sync_r <= 3'b000;
    else
      sync_r <= {sync_r[1:0], cmp_raw};
  end

  // Held result, frozen from the cycle the request drops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      synced_result_r <= 1'b0;
      result_prev_r <= 1'b0;
    end
    else
    begin
      result_prev_r <= synced_result_r;
      if (settled && normal_req && sync_r[2] == sync_r[1])
        synced_result_r <= sync_r[2];
    end
  end

  // Output pin with polarity, low in shutdown when not inverted
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pin_r <= 1'b0;
    else if (!settled && state_r == ST_OFF)
      pin_r <= control_r[CTL_POLARITY];
    else
      pin_r <= synced_result_r ^ control_r[CTL_POLARITY];
  end

  // Delay line on the previous result, in step with the pin, for flag timing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_d1_r <= 1'b0;
      pin_d2_r <= 1'b0;
    end
    else
    begin
      pin_d1_r <= result_prev_r;
      pin_d2_r <= pin_d1_r;
    end
  end

  // Edge detection on the delayed result
  always_comb
  begin
    unique case (edge_mode)
      EDGE_OFF: edge_hit = 1'b0;
      EDGE_RISE: edge_hit = pin_d1_r && !pin_d2_r;
      EDGE_FALL: edge_hit = !pin_d1_r && pin_d2_r;
      EDGE_BOTH: edge_hit = pin_d1_r ^ pin_d2_r;
    endcase
  end

  // Sticky edge flag, set beats clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      edge_flag_r <= 1'b0;
    else if (edge_hit)
      edge_flag_r <= 1'b1;
    else if (wr_status && wdata[ST_FLAG])
      edge_flag_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Pin, timer link and interrupt
  assign result_output_pin = pin_r;
  assign result_output_oe = control_r[CTL_PIN_EN];
  assign timer_capture = synced_result_r;
  assign irq = irq_en_r && edge_flag_r && flag_mask_r;

  // Analog core controls
  assign core_enable = normal_req;
  assign positive_input_select = routing_r[3:2];
  assign negative_input_select = routing_r[1:0];
  assign hysteresis_select = control_r[CTL_HYST_LO +: 2];
  assign filter_speed_select = control_r[CTL_FILTER];

endmodule // comparator_control

`default_nettype wire

/* test/cmp_core_model.sv */
// Behavioural analog comparator core with four selectable sources.
// Assumes source levels come from the bench as logic levels.
`timescale 1ns/1ps
`default_nettype none
module cmp_core_model #(parameter int DLY = 5) (
  input wire logic enable,
  input wire logic [1:0] pos_sel,
  input wire logic [1:0] neg_sel,
  input wire logic [3:0] src,
  output logic out
);
  // High when the plus source is above the minus one; held while off
  initial out = 1'h0;
  always @(enable, pos_sel, neg_sel, src)
    if (enable)
      out <= #DLY src[pos_sel] & ~src[neg_sel];
endmodule // cmp_core_model
`default_nettype wire

/* test/comparator_control_chk.sv */
// Port checker for the comparator control block.
// Assumes one clock hclk and the asynchronous active-low hresetn.
`timescale 1ns/1ps
`default_nettype none
module comparator_control_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic stop_mode,
  input wire logic core_enable,
  input wire logic [1:0] positive_input_select,
  input wire logic [1:0] negative_input_select,
  input wire logic timer_capture,
  input wire logic irq
);
  logic [7:0] on_cnt_r;
  logic wr_req;
  // Write address phase seen on the bus
  assign wr_req = hsel && htrans[1] && hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles spent with the core enabled, saturating
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      on_cnt_r <= 8'h00;
    else if (!core_enable)
      on_cnt_r <= 8'h00;
    else if (on_cnt_r != 8'hff)
      on_cnt_r <= on_cnt_r + 8'h01;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_okay; hreadyout && !hresp; endproperty
  property p_stop_off; stop_mode |-> !core_enable; endproperty
  property p_core_change;
    $changed(core_enable) |-> $changed(stop_mode) || $past(wr_req, 2);
  endproperty
  property p_init_hold; $changed(timer_capture) |-> on_cnt_r >= 8'h7f; endproperty
  property p_retain; $fell(core_enable) |=> $stable(timer_capture) [*4]; endproperty
  property p_sel_locked;
    $changed({positive_input_select, negative_input_select}) |-> !$past(core_enable);
  endproperty
  property p_irq_cause;
    $rose(irq) |-> $past(timer_capture, 3) != $past(timer_capture, 4)
      || $past(wr_req, 2);
  endproperty
  property p_irq_fall; $fell(irq) |-> $past(wr_req, 2); endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  a_stop_off: assert property (p_stop_off) else $error("core on in stop");
  a_core_change: assert property (p_core_change) else $error("core enable moved alone");
  a_init_hold: assert property (p_init_hold) else $error("result moved in init");
  a_retain: assert property (p_retain) else $error("result lost at shutdown");
  a_sel_locked: assert property (p_sel_locked) else $error("select changed while on");
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  c_irq: cover property ($rose(irq));
  c_init: cover property ($changed(timer_capture));
  c_stop: cover property (stop_mode && $past(core_enable));
endmodule // comparator_control_chk
bind comparator_control comparator_control_chk chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hreadyout, .hresp, .stop_mode, .core_enable, .positive_input_select,
  .negative_input_select, .timer_capture, .irq);
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the comparator control block.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cmp_ctrl_pkg::*;
;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h1;
  logic hwrite = 1'h0;
  logic stop_mode = 1'h0;
  logic wait_mode = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] src = 4'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, cmp_raw, core_enable, filter_speed_select, irq;
  logic result_output_pin, result_output_oe, timer_capture;
  logic [1:0] positive_input_select, negative_input_select, hysteresis_select;
  int fail_count = 0;
  int comparisons = 0;
  // Clock at 20 MHz
  always #25 hclk = ~hclk;
  comparator_control dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .stop_mode, .wait_mode, .cmp_raw,
    .core_enable, .positive_input_select, .negative_input_select, .hysteresis_select,
    .filter_speed_select, .result_output_pin, .result_output_oe, .timer_capture, .irq);
  cmp_core_model model (.enable(core_enable), .pos_sel(positive_input_select),
    .neg_sel(negative_input_select), .src(src), .out(cmp_raw));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] wd);
    haddr <= {26'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
    bus(1'h0, idx, 32'h0);
    check(rd, exp);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [3:0] idx [6] = '{IDX_CONTROL, IDX_ROUTING, IDX_IRQ_EN, IDX_STATUS, IDX_RSVD_LO,
      IDX_WAKE_MASK};
    for (int i = 0; i < 6; i++)
      rd_chk(idx[i], 32'(i == 5));
    bus(1'h1, IDX_RSVD_HI, 32'hff);
    rd_chk(IDX_RSVD_HI, 32'h0);
    rd_chk(4'h9, 32'h0);
    bus(1'h1, IDX_ROUTING, 32'hff);
    rd_chk(IDX_ROUTING, 32'h33);
    check(32'({positive_input_select, negative_input_select}), 32'hf);
    bus(1'h1, IDX_CONTROL, 32'h1c);
    cyc(1);
    check(32'({hysteresis_select, filter_speed_select}), 32'h7);
    bus(1'h1, IDX_IRQ_EN, 32'hff);
    rd_chk(IDX_IRQ_EN, 32'h1);
    $display("registers test done");
  endtask
  task automatic t_init;
    bus(1'h1, IDX_ROUTING, 32'h01);
    src <= 4'h1;
    bus(1'h1, IDX_CONTROL, 32'hc1);
    cyc(120);
    check(32'(timer_capture), 32'h0);
    rd_chk(IDX_STATUS, 32'h0);
    bus(1'h1, IDX_ROUTING, 32'h32);
    cyc(20);
    rd_chk(IDX_STATUS, 32'h81);
    rd_chk(IDX_ROUTING, 32'h01);
    check(32'({timer_capture, result_output_pin, result_output_oe, irq}), 32'hf);
    $display("init test done");
  endtask
  task automatic t_edges;
    for (int m = 0; m < 4; m++)
    begin
      bus(1'h1, IDX_CONTROL, 32'hc0 | 32'(m));
      bus(1'h1, IDX_STATUS, 32'h1);
      src <= 4'h0;
      cyc(10);
      rd_chk(IDX_STATUS, 32'(m[1]));
      bus(1'h1, IDX_STATUS, 32'h1);
      src <= 4'h1;
      do @(posedge hclk); while (result_output_pin !== 1'h1);
      cyc(1);
      check(32'(irq), 32'h0);
      cyc(1);
      check(32'(irq), 32'(m[0]));
      cyc(4);
      rd_chk(IDX_STATUS, 32'h80 | 32'(m[0]));
      check(32'(irq), 32'(m[0]));
    end
    bus(1'h1, IDX_IRQ_EN, 32'h0);
    cyc(1);
    check(32'(irq), 32'h0);
    bus(1'h1, IDX_IRQ_EN, 32'h1);
    bus(1'h1, IDX_WAKE_MASK, 32'h0);
    cyc(1);
    check(32'(irq), 32'h0);
    rd_chk(IDX_WAKE_MASK, 32'h0);
    bus(1'h1, IDX_WAKE_MASK, 32'h1);
    cyc(1);
    check(32'(irq), 32'h1);
    bus(1'h1, IDX_STATUS, 32'h1);
    cyc(1);
    check(32'(irq), 32'h0);
    $display("edge test done");
  endtask
  task automatic t_modes;
    bus(1'h1, IDX_CONTROL, 32'he0);
    cyc(3);
    check(32'(result_output_pin), 32'h0);
    src <= 4'h0;
    cyc(10);
    check(32'(result_output_pin), 32'h1);
    bus(1'h1, IDX_CONTROL, 32'h40);
    cyc(1);
    src <= 4'h1;
    cyc(9);
    check(32'({core_enable, result_output_pin, timer_capture}), 32'h0);
    rd_chk(IDX_STATUS, 32'h0);
    bus(1'h1, IDX_CONTROL, 32'h80);
    wait_mode <= 1'h1;
    cyc(2);
    check(32'(core_enable), 32'h1);
    stop_mode <= 1'h1;
    cyc(2);
    check(32'(core_enable), 32'h0);
    stop_mode <= 1'h0;
    wait_mode <= 1'h0;
    cyc(20);
    check(32'(timer_capture), 32'h0);
    $display("modes test done");
  endtask
  // Main sequence after the reset hold
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs;
    t_init;
    t_edges;
    t_modes;
    end_of_test;
  end
  // Watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
